// ===== inc/txsc_regs.svh
/*
  Named constants of the transmit state control block: timing figures,
  command words and field limits.
  Assumes inclusion by bare name from the design modules.
*/
`ifndef TXSC_REGS_SVH
`define TXSC_REGS_SVH

`define TXSC_CLK_PERIOD_NS 10
`define TXSC_NS_PER_US 1000
`define TXSC_NS_PER_MS 1000000
`define TXSC_OSC_STARTUP_US 400
`define TXSC_TUNE_US 370
`define TXSC_SOFT_WAIT_MS 1
`define TXSC_STOP_FINE_BASE_MS 2
`define TXSC_STOP_COARSE_BASE_MS 20
`define TXSC_STOP_COARSE_STEP_MS 10
`define TXSC_STOP_FINE_LAST 4'h7
`define TXSC_STOP_COARSE_LAST 4'hE
`define TXSC_STOP_COARSE_FIRST 8
`define TXSC_STOP_COARSE_STEPS 7
`define TXSC_RAMP_SEL_MAX 4'hB
`define TXSC_CMD_IFACE_RESET 16'h8D00
`define TXSC_CMD_IFACE_OFF 16'hBD01
`define TXSC_CMD_SOFT_RESET 16'h8D02
`define TXSC_LEAD_ZEROS 6'h20
`define TXSC_WORD_LAST 4'hF

`endif

// ===== inc/txsc_pkg.sv
/*
  Types of the transmit state control block.
  Assumes txsc_regs.svh on the include path.
*/
package txsc_pkg;

  // ----------------------------------------
  // Working states, Gray coded around the cycle.
  // ----------------------------------------
  typedef enum logic [1:0] {
    TXSC_SLEEP = 2'h0,
    TXSC_OSC_STARTUP = 2'h1,
    TXSC_TUNE = 2'h3,
    TXSC_TRANSMIT = 2'h2
  } txsc_state_type;

  // ----------------------------------------
  // Configuration, event and power carriers.
  // ----------------------------------------
  typedef struct packed {
    logic start_falling;
    logic ook_mode;
    logic [3:0] ramp_sel;
    logic [3:0] stop_sel;
  } txsc_cfg_type;

  typedef struct packed {
    logic iface_reset_cmd;
    logic iface_off_cmd;
    logic soft_reset;
  } txsc_evt_type;

  typedef struct packed {
    logic osc_en;
    logic synth_en;
    logic pa_enable;
    logic pa_at_level;
  } txsc_pwr_type;

endpackage : txsc_pkg

// ===== logic/txsc_ramp.sv
/*
  Power amplifier ramp timer: equal ramp up and ramp down durations.
  Assumes ramp settings that are stable while the amplifier is requested.
*/
`timescale 1ns/10ps
`include "txsc_regs.svh"

module txsc_ramp
  import txsc_pkg::*;
#(
  parameter int CYC_PER_US = `TXSC_NS_PER_US / `TXSC_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Settings and request.
  input wire logic ook_mode,
  input wire logic [3:0] ramp_sel,
  input wire logic pa_request,
  // Amplifier drive.
  output logic pa_enable,
  output logic pa_at_level
);

  if (CYC_PER_US < 1 || CYC_PER_US * 1024 >= 2 ** 20) begin : g_chk
    $error("txsc_ramp: CYC_PER_US out of range.");
  end

  typedef struct packed {
    logic [19:0] level;
    logic enable;
    logic at_level;
  } txsc_ramp_type;

  txsc_ramp_type r;
  txsc_ramp_type next_r;
  logic [19:0] ramp_len;
  logic [3:0] sel;

  // ----------------------------------------
  // Ramp length.
  // ----------------------------------------
  always_comb begin
    sel = (ramp_sel > `TXSC_RAMP_SEL_MAX) ? `TXSC_RAMP_SEL_MAX : ramp_sel;
    if (!ook_mode || sel == 4'h0) begin
      ramp_len = 20'h00000;
    end else begin
      ramp_len = 20'(CYC_PER_US) << (sel - 4'h1);
    end
  end

  // ----------------------------------------
  // Level counter.
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (pa_request) begin
      if (r.level < ramp_len) begin
        next_r.level = r.level + 20'h00001;
      end else begin
        next_r.level = ramp_len;
      end
      next_r.enable = 1'b1;
      next_r.at_level = (r.level == ramp_len);
    end else begin
      if (r.level > ramp_len) begin
        next_r.level = ramp_len;
      end else if (r.level != 20'h00000) begin
        next_r.level = r.level - 20'h00001;
      end
      next_r.at_level = 1'b0;
      next_r.enable = (r.level != 20'h00000);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pa_enable = r.enable;
  assign pa_at_level = r.at_level;

endmodule : txsc_ramp

// ===== logic/txsc_twi.sv
/*
  Two-wire command port receiver on the host clock, sampling on its
  falling edge. Each command found flips one toggle line.
  Assumes the host clock is still outside commands.
*/
`timescale 1ns/10ps
`include "txsc_regs.svh"

module txsc_twi
  import txsc_pkg::*;
(
  // Link clock and reset.
  input wire logic link_clk,
  input wire logic resetn,
  // Link data.
  input wire logic link_data,
  // Command toggles.
  output txsc_evt_type cmd_toggle
);

  typedef struct packed {
    logic [5:0] zero_run;
    logic armed;
    logic [3:0] bit_cnt;
    logic [15:0] word;
    txsc_evt_type tog;
  } txsc_twi_type;

  txsc_twi_type s;
  txsc_twi_type next_s;
  logic [15:0] shifted;

  // ----------------------------------------
  // Command decoder.
  // ----------------------------------------
  always_comb begin
    next_s = s;
    shifted = {s.word[14:0], link_data};
    next_s.word = shifted;
    if (link_data) begin
      next_s.zero_run = 6'h00;
    end else if (s.zero_run < `TXSC_LEAD_ZEROS) begin
      next_s.zero_run = s.zero_run + 6'h01;
    end
    if (s.armed) begin
      next_s.bit_cnt = s.bit_cnt + 4'h1;
      if (s.bit_cnt == `TXSC_WORD_LAST) begin
        next_s.armed = 1'b0;
        if (shifted == `TXSC_CMD_IFACE_RESET) begin
          next_s.tog.iface_reset_cmd = ~s.tog.iface_reset_cmd;
        end
      end
    end else if (link_data && s.zero_run == `TXSC_LEAD_ZEROS) begin
      next_s.armed = 1'b1;
      next_s.bit_cnt = 4'h1;
    end else if (shifted == `TXSC_CMD_IFACE_OFF) begin
      next_s.tog.iface_off_cmd = ~s.tog.iface_off_cmd;
      next_s.word = 16'h0000;
    end else if (shifted == `TXSC_CMD_SOFT_RESET) begin
      next_s.tog.soft_reset = ~s.tog.soft_reset;
      next_s.word = 16'h0000;
    end
  end

  always_ff @(negedge link_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cmd_toggle = s.tog;

endmodule : txsc_twi

// ===== logic/txsc_top.sv
/*
  Transmit state control: sleep, oscillator start-up, tuning and transmit,
  started by an edge on the data pin and ended by a long low level or by a
  soft reset command on the two-wire port.
  Assumes configuration inputs that are steady in the core clock domain and
  a data pin and host clock that are asynchronous to the core clock.
*/
// What this block does
// - Ramp times 0 and 1 to 1024 us in powers of two, OOK only.
// - Ramp setting zero reaches output level as fast as possible.
// - Ramp down lasts exactly as long as ramp up.
// - Four working states: sleep, start-up, tuning, transmit.
// - Sleep switches oscillator, synthesizer and amplifier request off; the port stays on.
// - Configured rising or falling data edge leaves sleep for start-up.
// - Amplifier on only after the 370 us tuning; earlier data is dropped.
// - Transmit ends after data low for 2-9 ms or 20-90 ms.
// - Soft reset command stops transmission within 1 ms.
// - Interface reset is 32 low clocks then word 8D00, 48 clocks.
// - After interface reset start edges are ignored until interface off.
// - Interface off is word BD01 and re-enables start edge detection.
// - Soft reset resets all but the port and sleeps at once while it calibrates.
// - Host changes data on clock rise; device samples on clock fall.
`timescale 1ns/10ps
`include "txsc_regs.svh"

module txsc_top
  import txsc_pkg::*;
#(
  parameter int OSC_STARTUP_CYCLES = `TXSC_OSC_STARTUP_US * `TXSC_NS_PER_US / `TXSC_CLK_PERIOD_NS,
  parameter int TUNE_CYCLES = `TXSC_TUNE_US * `TXSC_NS_PER_US / `TXSC_CLK_PERIOD_NS,
  parameter int MS_CYCLES = `TXSC_NS_PER_MS / `TXSC_CLK_PERIOD_NS,
  parameter int SOFT_WAIT_CYCLES = `TXSC_SOFT_WAIT_MS * MS_CYCLES,
  parameter int CYC_PER_US = `TXSC_NS_PER_US / `TXSC_CLK_PERIOD_NS
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Two-wire port pins.
  input wire logic link_clk,
  input wire logic data_pin,
  // Configuration.
  input wire logic start_falling,
  input wire logic ook_mode,
  input wire logic [3:0] ramp_sel,
  input wire logic [3:0] stop_sel,
  // Status and analog controls.
  output txsc_state_type tx_state,
  output logic port_active,
  output logic calib_busy,
  output logic osc_en,
  output logic synth_en,
  output logic pa_enable,
  output logic pa_at_level,
  output logic tx_data
);

  // ----------------------------------------
  // Elaboration checks.
  // ----------------------------------------
  if (OSC_STARTUP_CYCLES < 1 || OSC_STARTUP_CYCLES >= 2 ** 24) begin : g_chk_osc
    $error("txsc_top: OSC_STARTUP_CYCLES out of range.");
  end
  if (TUNE_CYCLES < 1 || TUNE_CYCLES >= 2 ** 24) begin : g_chk_tune
    $error("txsc_top: TUNE_CYCLES out of range.");
  end
  if (MS_CYCLES < 1 || MS_CYCLES * 90 >= 2 ** 24) begin : g_chk_ms
    $error("txsc_top: MS_CYCLES out of range.");
  end
  if (SOFT_WAIT_CYCLES < 1 || SOFT_WAIT_CYCLES >= 2 ** 24) begin : g_chk_soft
    $error("txsc_top: SOFT_WAIT_CYCLES out of range.");
  end

  // ----------------------------------------
  // State of the core domain.
  // ----------------------------------------
  typedef struct packed {
    txsc_state_type st;
    logic [2:0] rst_sync;
    logic [2:0] off_sync;
    logic [2:0] soft_sync;
    logic [1:0] din_sync;
    logic din_prev;
    logic port_active;
    logic [23:0] timer;
    logic [23:0] cal_timer;
    logic calib_busy;
    txsc_pwr_type pwr;
    logic pa_req;
    logic tx_data;
  } txsc_core_type;

  txsc_core_type c;
  txsc_core_type next_c;
  txsc_cfg_type cfg;
  txsc_evt_type link_tog;
  txsc_evt_type evt;
  logic din;
  logic start_edge;
  logic [23:0] stop_cycles;
  logic ramp_enable;
  logic ramp_at_level;

  assign cfg = '{start_falling: start_falling, ook_mode: ook_mode, ramp_sel: ramp_sel, stop_sel: stop_sel};

  // ----------------------------------------
  // Two-wire port on the link clock.
  // ----------------------------------------
  txsc_twi u_twi (
    .link_clk(link_clk),
    .resetn(resetn),
    .link_data(data_pin),
    .cmd_toggle(link_tog)
  );

  // ----------------------------------------
  // Amplifier ramp.
  // ----------------------------------------
  txsc_ramp #(
    .CYC_PER_US(CYC_PER_US)
  ) u_ramp (
    .core_clk(core_clk),
    .resetn(resetn),
    .ook_mode(cfg.ook_mode),
    .ramp_sel(cfg.ramp_sel),
    .pa_request(c.pa_req),
    .pa_enable(ramp_enable),
    .pa_at_level(ramp_at_level)
  );

  // ----------------------------------------
  // Stop time from its setting.
  // ----------------------------------------
  always_comb begin
    if (cfg.stop_sel <= `TXSC_STOP_FINE_LAST) begin
      stop_cycles = 24'(MS_CYCLES * (`TXSC_STOP_FINE_BASE_MS + int'(cfg.stop_sel)));
    end else if (cfg.stop_sel <= `TXSC_STOP_COARSE_LAST) begin
      stop_cycles = 24'(MS_CYCLES * (`TXSC_STOP_COARSE_BASE_MS
        + `TXSC_STOP_COARSE_STEP_MS * (int'(cfg.stop_sel) - `TXSC_STOP_COARSE_FIRST)));
    end else begin
      stop_cycles = 24'(MS_CYCLES * (`TXSC_STOP_COARSE_BASE_MS
        + `TXSC_STOP_COARSE_STEP_MS * `TXSC_STOP_COARSE_STEPS));
    end
  end

  // ----------------------------------------
  // Crossing events and start edge.
  // ----------------------------------------
  always_comb begin
    evt.iface_reset_cmd = c.rst_sync[1] ^ c.rst_sync[2];
    evt.iface_off_cmd = c.off_sync[1] ^ c.off_sync[2];
    evt.soft_reset = c.soft_sync[1] ^ c.soft_sync[2];
    din = c.din_sync[1];
    if (cfg.start_falling) begin
      start_edge = c.din_prev & ~din;
    end else begin
      start_edge = ~c.din_prev & din;
    end
  end

  // ----------------------------------------
  // Working state machine.
  // ----------------------------------------
  always_comb begin
    next_c = c;
    next_c.rst_sync = {c.rst_sync[1:0], link_tog.iface_reset_cmd};
    next_c.off_sync = {c.off_sync[1:0], link_tog.iface_off_cmd};
    next_c.soft_sync = {c.soft_sync[1:0], link_tog.soft_reset};
    next_c.din_sync = {c.din_sync[0], data_pin};
    next_c.din_prev = din;
    if (evt.iface_reset_cmd) begin
      next_c.port_active = 1'b1;
    end else if (evt.iface_off_cmd) begin
      next_c.port_active = 1'b0;
    end
    if (c.calib_busy) begin
      if (c.cal_timer == 24'(SOFT_WAIT_CYCLES - 1)) begin
        next_c.calib_busy = 1'b0;
      end else begin
        next_c.cal_timer = c.cal_timer + 24'h000001;
      end
    end
    case (c.st)
      TXSC_SLEEP: begin
        next_c.timer = 24'h000000;
        if (start_edge && !c.port_active && !c.calib_busy) begin
          next_c.st = TXSC_OSC_STARTUP;
        end
      end
      TXSC_OSC_STARTUP: begin
        if (c.timer == 24'(OSC_STARTUP_CYCLES - 1)) begin
          next_c.timer = 24'h000000;
          next_c.st = TXSC_TUNE;
        end else begin
          next_c.timer = c.timer + 24'h000001;
        end
      end
      TXSC_TUNE: begin
        if (c.timer == 24'(TUNE_CYCLES - 1)) begin
          next_c.timer = 24'h000000;
          next_c.st = TXSC_TRANSMIT;
        end else begin
          next_c.timer = c.timer + 24'h000001;
        end
      end
      TXSC_TRANSMIT: begin
        if (din) begin
          next_c.timer = 24'h000000;
        end else if (c.timer == stop_cycles - 24'h000001) begin
          next_c.timer = 24'h000000;
          next_c.st = TXSC_SLEEP;
        end else begin
          next_c.timer = c.timer + 24'h000001;
        end
      end
      default: begin
        next_c.timer = 24'h000000;
        next_c.st = TXSC_SLEEP;
      end
    endcase
    if (evt.soft_reset) begin
      next_c.st = TXSC_SLEEP;
      next_c.timer = 24'h000000;
      next_c.calib_busy = 1'b1;
      next_c.cal_timer = 24'h000000;
    end
    next_c.pwr.osc_en = (next_c.st != TXSC_SLEEP);
    next_c.pwr.synth_en = (next_c.st == TXSC_TUNE) || (next_c.st == TXSC_TRANSMIT);
    next_c.pa_req = (next_c.st == TXSC_TRANSMIT);
    next_c.pwr.pa_enable = ramp_enable;
    next_c.pwr.pa_at_level = ramp_at_level;
    next_c.tx_data = (c.st == TXSC_TRANSMIT) && ramp_at_level && din;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  assign tx_state = c.st;
  assign port_active = c.port_active;
  assign calib_busy = c.calib_busy;
  assign osc_en = c.pwr.osc_en;
  assign synth_en = c.pwr.synth_en;
  assign pa_enable = c.pwr.pa_enable;
  assign pa_at_level = c.pwr.pa_at_level;
  assign tx_data = c.tx_data;

endmodule : txsc_top

// ===== dv/txsc_top_assertions.sv
/*
  Checker of the transmit state control top ports.
  Assumes binding into txsc_top with its cycle parameters.
*/
`timescale 1ns/10ps

module txsc_top_checker
  import txsc_pkg::*;
#(
  parameter int OSC_STARTUP_CYCLES = 20,
  parameter int TUNE_CYCLES = 15,
  parameter int SOFT_WAIT_CYCLES = 40
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Watched outputs.
  input txsc_state_type tx_state,
  input wire logic port_active,
  input wire logic calib_busy,
  input wire logic osc_en,
  input wire logic synth_en,
  input wire logic pa_enable,
  input wire logic tx_data
);
  // ----
  // Helper counters.
  // ----
  txsc_state_type prev_state;
  int st_cnt;
  int cb_cnt;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev_state <= TXSC_SLEEP;
      st_cnt <= 0;
      cb_cnt <= 0;
    end else begin
      prev_state <= tx_state;
      st_cnt <= (tx_state != prev_state) ? 1 : st_cnt + 1;
      cb_cnt <= calib_busy ? cb_cnt + 1 : 0;
    end
  end

  // ----
  // Properties.
  // ----
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence enter_osc;
    tx_state == TXSC_OSC_STARTUP && prev_state != TXSC_OSC_STARTUP;
  endsequence

  sequence enter_tx;
    tx_state == TXSC_TRANSMIT && prev_state == TXSC_TUNE;
  endsequence

  a_sleep_all_off: assert property (tx_state == TXSC_SLEEP && prev_state == TXSC_SLEEP |->
    !osc_en && !synth_en && !tx_data) else $error("Block powered in sleep.");
  a_start_from_sleep: assert property (enter_osc |-> prev_state == TXSC_SLEEP)
    else $error("Start-up entered from a wrong state.");
  a_osc_length: assert property (tx_state == TXSC_TUNE && prev_state == TXSC_OSC_STARTUP |->
    st_cnt == OSC_STARTUP_CYCLES) else $error("Start-up length wrong.");
  a_tune_length: assert property (enter_tx |-> st_cnt == TUNE_CYCLES)
    else $error("Tuning length wrong.");
  a_pa_after_tune: assert property ($rose(pa_enable) |-> tx_state == TXSC_TRANSMIT)
    else $error("Amplifier on outside transmit.");
  a_port_blocks_start: assert property (enter_osc |-> !$past(port_active))
    else $error("Start taken while port active.");
  a_calib_blocks_start: assert property (enter_osc |-> !$past(calib_busy))
    else $error("Start taken during calibration.");
  a_calib_length: assert property (!calib_busy && cb_cnt != 0 |-> cb_cnt == SOFT_WAIT_CYCLES)
    else $error("Calibration length wrong.");
  a_soft_to_sleep: assert property ($rose(calib_busy) |-> ##[0:1] tx_state == TXSC_SLEEP)
    else $error("Soft reset left transmit running.");
  a_tx_powered: assert property (tx_state == TXSC_TRANSMIT |-> osc_en && synth_en)
    else $error("Transmit without oscillator or synthesizer.");
  a_data_gated: assert property (tx_data |-> pa_enable &&
    (tx_state == TXSC_TRANSMIT || prev_state == TXSC_TRANSMIT)) else $error("Data passed outside transmit.");
endmodule : txsc_top_checker

bind txsc_top txsc_top_checker #(
  .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES),
  .TUNE_CYCLES(TUNE_CYCLES),
  .SOFT_WAIT_CYCLES(SOFT_WAIT_CYCLES)
) txsc_top_checker_inst (
  .core_clk(core_clk),
  .resetn(resetn),
  .tx_state(tx_state),
  .port_active(port_active),
  .calib_busy(calib_busy),
  .osc_en(osc_en),
  .synth_en(synth_en),
  .pa_enable(pa_enable),
  .tx_data(tx_data)
);

// ===== dv/txsc_host_model.sv
/*
  Host model: drives the data pin and the port clock.
  Assumes calls from the testbench; the clock idles high.
*/
`timescale 1ns/10ps

module txsc_host_model
  import txsc_pkg::*;
(
  // Host pins.
  output logic link_clk,
  output logic data_pin
);
  initial begin
    link_clk = 1'b1;
    data_pin = 1'b0;
  end

  task automatic set_data(input logic v);
    data_pin = v;
  endtask : set_data

  // Sends n bits, first clock fall 25 ns after the first bit.
  task automatic send_bits(input logic [47:0] w, input int n, input logic idle);
    data_pin = w[n-1];
    #10;
    for (int i = n - 1; i >= 0; i--) begin
      data_pin = w[i];
      #15 link_clk = 1'b0;
      #15 link_clk = 1'b1;
    end
    data_pin = idle;
  endtask : send_bits
endmodule : txsc_host_model

// ===== dv/tb_txsc_top.sv
/*
  Testbench of the transmit state control block.
  Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/10ps

module tb_txsc_top
  import txsc_pkg::*;
;
  logic core_clk, resetn, start_falling, ook_mode, seen_lvl;
  logic [3:0] ramp_sel, stop_sel;
  wire logic link_clk, data_pin;
  txsc_state_type tx_state;
  logic port_active, calib_busy, osc_en, synth_en, pa_enable, pa_at_level, tx_data;
  int failures, n_tests, up_n, dn_n, t;
  int ups[3];

  txsc_host_model txsc_host_model_inst (.link_clk(link_clk), .data_pin(data_pin));

  txsc_top #(.OSC_STARTUP_CYCLES(20), .TUNE_CYCLES(15), .MS_CYCLES(50), .SOFT_WAIT_CYCLES(40),
    .CYC_PER_US(2)) txsc_top_inst (.core_clk(core_clk), .resetn(resetn), .link_clk(link_clk),
    .data_pin(data_pin), .start_falling(start_falling), .ook_mode(ook_mode), .ramp_sel(ramp_sel),
    .stop_sel(stop_sel), .tx_state(tx_state), .port_active(port_active), .calib_busy(calib_busy),
    .osc_en(osc_en), .synth_en(synth_en), .pa_enable(pa_enable), .pa_at_level(pa_at_level),
    .tx_data(tx_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Counts ramp up and ramp down cycles of the amplifier.
  always @(posedge core_clk) begin
    if (!pa_enable) seen_lvl <= 1'b0;
    else if (pa_at_level) seen_lvl <= 1'b1;
    else if (seen_lvl) dn_n <= dn_n + 1;
    else up_n <= up_n + 1;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wait_st(input txsc_state_type s, input int lim, output int took);
    took = 0;
    while (tx_state !== s && took < lim) begin
      tick(1);
      took++;
    end
    if (tx_state !== s) begin
      failures++;
      $display("[FAIL] state wait expected %s seen %s", s.name(), tx_state.name());
      tally_and_finish();
    end
  endtask : wait_st

  task automatic cmd(input logic [47:0] w, input int n);
    txsc_host_model_inst.send_bits(w, n, 1'b0);
    tick(6);
  endtask : cmd

  task automatic pin(input logic v);
    txsc_host_model_inst.set_data(v);
  endtask : pin

  // One rising-start cycle ended by a long low level.
  task automatic tx_cycle(input logic [3:0] rs, input logic [3:0] ss, input logic ook, output int up);
    int sc;
    sc = ss < 8 ? (ss + 2) * 50 : (ss - 6) * 500;
    ook_mode = ook;
    ramp_sel = rs;
    stop_sel = ss;
    up_n = 0;
    dn_n = 0;
    pin(1'b1);
    wait_st(TXSC_OSC_STARTUP, 8, t);
    wait_st(TXSC_TRANSMIT, 40, t);
    check("pa before transmit", pa_enable, 0);
    tick(30);
    check("pa at level", pa_at_level, 1);
    pin(1'b0);
    tick(16);
    check("data low", tx_data, 0);
    pin(1'b1);
    tick(16);
    check("data high", tx_data, 1);
    pin(1'b0);
    wait_st(TXSC_SLEEP, sc + 10, t);
    check("stop time", t >= sc - 2, 1);
    tick(20);
    check("sleep off", {osc_en, synth_en, pa_enable}, 0);
    check("ramp symmetry", dn_n, up_n);
    up = up_n;
  endtask : tx_cycle

  initial begin
    resetn = 1'b0;
    start_falling = 1'b0;
    ook_mode = 1'b1;
    ramp_sel = 4'h0;
    stop_sel = 4'h0;
    failures = 0;
    n_tests = 0;
    seen_lvl = 1'b0;
    tick(12);
    resetn = 1'b1;
    tick(1);
    check("reset outputs", {tx_state, port_active, calib_busy, osc_en, pa_enable, tx_data}, 0);
    cmd(48'h8D00, 16);
    check("bare word", port_active, 0);
    cmd(48'h8D00, 48);
    check("port reset", port_active, 1);
    cmd(48'h8D02, 16);
    check("soft sleep", tx_state, TXSC_SLEEP);
    check("calibrating", calib_busy, 1);
    check("port kept", port_active, 1);
    tick(50);
    pin(1'b1);
    tick(10);
    check("edge ignored", tx_state, TXSC_SLEEP);
    pin(1'b0);
    cmd(48'h8D00, 48);
    cmd(48'hBD01, 16);
    check("port off", port_active, 0);
    tx_cycle(4'h0, 4'h0, 1'b1, ups[0]);
    tx_cycle(4'h3, 4'h7, 1'b1, ups[1]);
    tx_cycle(4'h3, 4'h8, 1'b0, ups[2]);
    check("ramp step", ups[1] - ups[0], 8);
    check("ramp off in fsk", ups[2], ups[0]);
    stop_sel = 4'h7;
    pin(1'b1);
    wait_st(TXSC_TRANSMIT, 45, t);
    cmd(48'h8D00, 48);
    cmd(48'h8D02, 16);
    check("soft stop", tx_state, TXSC_SLEEP);
    tick(50);
    cmd(48'hBD01, 16);
    start_falling = 1'b1;
    stop_sel = 4'h0;
    pin(1'b1);
    tick(10);
    check("rise ignored", tx_state, TXSC_SLEEP);
    pin(1'b0);
    wait_st(TXSC_OSC_STARTUP, 8, t);
    wait_st(TXSC_SLEEP, 170, t);
    pin(1'b1);
    tick(4);
    check("falling cycle end", osc_en, 0);
    tally_and_finish();
  end
endmodule : tb_txsc_top
